// *** inc/tfps_pkg.sv ***
// Package with constants and types of the thermal fan sequencer
package tfps_pkg;
   localparam int TFPS_DUTY_W = 8;
   localparam int TFPS_STARTUP_PERIODS = 64;
   localparam logic [TFPS_DUTY_W-1:0] TFPS_DUTY_ZERO = 8'h00;
   localparam logic [TFPS_DUTY_W-1:0] TFPS_DUTY_FULL = 8'hff;

   typedef enum logic [1:0] {
      TFPS_ST_SHUT = 2'b00,
      TFPS_ST_START = 2'b01,
      TFPS_ST_RUN = 2'b11,
      TFPS_ST_SLEEP = 2'b10
   } tfps_state_t;

   // Threshold comparator results, each high while the condition holds
   typedef struct packed {
      logic restart;
      logic primary_below_sleep;
      logic secondary_below_sleep;
      logic primary_above_wake;
      logic secondary_above_wake;
      logic overtemp;
      logic full_duty;
   } tfps_cmp_t;
endpackage

// *** src/tfps_startup_timer.sv ***
// Startup interval counter of the thermal fan sequencer
`timescale 1ns/1ps
`default_nettype none
module tfps_startup_timer
   import tfps_pkg::*;
#(
   parameter int PERIODS = TFPS_STARTUP_PERIODS
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic start_i,
   output logic busy_o
);
   localparam int CW = $clog2(PERIODS + 1);
   // The entry cycle is already the first forced period, so one less is loaded
   localparam logic [CW-1:0] LOAD = CW'(PERIODS - 1);
   localparam logic [CW-1:0] ONE = CW'(1);

   if (PERIODS < 1) begin : g_periods_check
      $error("PERIODS must be at least one");
   end

   logic [CW-1:0] count;
   logic [CW-1:0] next_count;

   always_comb begin
      next_count = count;
      if (start_i) begin
         next_count = LOAD;
      end else if (count != '0) begin
         next_count = count - ONE;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

   assign busy_o = (count != '0);
endmodule
`default_nettype wire

// *** src/tfps_core.sv ***
// Digital core of the thermal fan sequencer: startup, control, fault, sleep, shutdown
// What this block does
// R01: Outside startup the duty comes from the higher of primary and secondary inputs.
// R02: Primary above the full-duty threshold holds the fan drive high.
// R03: Primary above the overtemperature threshold asserts the low-active fault flag, drive stays full.
// R04: The fault flag releases at the next time-base edge after primary drops below the overtemperature threshold.
// R05: Both inputs below the sleep threshold with primary above shutdown enter sleep.
// R06: Only one input below the sleep threshold keeps normal operation.
// R07: Either input above the wake threshold leaves sleep through a 64-period forced-high startup.
// R08: After power-on the drive is forced high for 64 time-base periods before proportional control.
// R09: Primary below the shutdown threshold stops everything at once, whatever the secondary does.
// R10: One time base clocks both the state logic and the modulation, one counter step per time-base cycle.
// R11: Primary rising above the restart threshold after shutdown acts as a full power-up reset.
// R12: In sleep the fault flag is inactive and the drive is off regardless of temperature.
// R13: Each input is a digital duty value, the higher one is compared with a free-running counter.
// R14: Threshold comparisons are sampled level inputs, shutdown alone acts asynchronously.
`timescale 1ns/1ps
`default_nettype none
module tfps_core
   import tfps_pkg::*;
#(
   parameter int DUTY_W = TFPS_DUTY_W,
   parameter int STARTUP_PERIODS = TFPS_STARTUP_PERIODS
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic shutdown_i,
   input wire tfps_cmp_t cmp_i,
   input wire logic [DUTY_W-1:0] primary_temp_input_i,
   input wire logic [DUTY_W-1:0] secondary_fan_input_i,
   output logic fan_drive_o,
   output logic fan_drive_oe_o,
   output logic overtemp_fault_n_o,
   output logic overtemp_fault_n_oe_o,
   output tfps_state_t state_o
);
   if (DUTY_W < 2 || DUTY_W > 16) begin : g_duty_w_check
      $error("DUTY_W must lie between 2 and 16");
   end
   // The wake check below counts the interval in one delay range, which tools cap
   if (STARTUP_PERIODS < 1 || STARTUP_PERIODS > 1000) begin : g_startup_check
      $error("STARTUP_PERIODS must lie between 1 and 1000");
   end

   localparam logic [DUTY_W-1:0] PWM_ONE = DUTY_W'(1);
   localparam int START_LEN = STARTUP_PERIODS;

   tfps_state_t state;
   tfps_state_t next_state;
   logic [DUTY_W-1:0] pwm_count;
   logic [DUTY_W-1:0] next_pwm_count;
   logic [DUTY_W-1:0] duty;
   logic [DUTY_W-1:0] next_duty;
   logic drive;
   logic next_drive;
   logic fault;
   logic next_fault;
   logic start_pulse;
   logic startup_busy;
   logic sleep_req;
   logic wake_req;

   // The sleep needs both inputs low, the wake needs either one high
   assign sleep_req = cmp_i.primary_below_sleep & cmp_i.secondary_below_sleep; // see R05 see R06
   assign wake_req = cmp_i.primary_above_wake | cmp_i.secondary_above_wake; // see R07

   always_comb begin
      next_state = state;
      start_pulse = 1'b0;
      case (state)
         TFPS_ST_SHUT: begin
            if (cmp_i.restart) begin
               next_state = TFPS_ST_START; // see R11 see R08
               start_pulse = 1'b1;
            end
         end
         TFPS_ST_START: begin
            if (!startup_busy && !start_pulse) begin
               next_state = TFPS_ST_RUN;
            end
         end
         TFPS_ST_RUN: begin
            if (sleep_req) begin
               next_state = TFPS_ST_SLEEP; // see R05
            end
         end
         TFPS_ST_SLEEP: begin
            if (wake_req) begin
               next_state = TFPS_ST_START; // see R07
               start_pulse = 1'b1;
            end
         end
         default: begin
            next_state = TFPS_ST_SHUT;
         end
      endcase
   end

   tfps_startup_timer #(
      .PERIODS(STARTUP_PERIODS)
   ) u_timer (
      .clk_i(clk_i),
      .reset_i(reset_i | shutdown_i),
      .start_i(start_pulse),
      .busy_o(startup_busy)
   );

   // Duty selection and modulation; one counter step per time-base cycle
   always_comb begin
      next_pwm_count = pwm_count + PWM_ONE; // see R10 see R13
      if (primary_temp_input_i >= secondary_fan_input_i) begin
         next_duty = primary_temp_input_i; // see R01
      end else begin
         next_duty = secondary_fan_input_i;
      end
      next_drive = 1'b0;
      next_fault = 1'b0;
      case (next_state)
         TFPS_ST_START: begin
            next_drive = 1'b1; // see R08 see R07
            next_fault = cmp_i.overtemp;
         end
         TFPS_ST_RUN: begin
            // Registered duty keeps the input compare off the path into the drive flop
            next_drive = cmp_i.full_duty || (next_pwm_count < duty); // see R02 see R13
            next_fault = cmp_i.overtemp; // see R03 see R04
         end
         default: begin
            next_drive = 1'b0; // see R12
            next_fault = 1'b0;
         end
      endcase
   end

   // Shutdown is level-sensitive and overrides the sampled path at once
   always_ff @(posedge clk_i or posedge shutdown_i) begin
      if (shutdown_i) begin
         state <= TFPS_ST_SHUT; // see R09 see R14
         pwm_count <= '0;
         duty <= '0;
         drive <= 1'b0;
         fault <= 1'b0;
      end else if (reset_i) begin
         state <= TFPS_ST_SHUT;
         pwm_count <= '0;
         duty <= '0;
         drive <= 1'b0;
         fault <= 1'b0;
      end else begin
         state <= next_state;
         pwm_count <= next_pwm_count;
         duty <= next_duty;
         drive <= next_drive;
         fault <= next_fault;
      end
   end

   // Drive floats in shutdown and sleep, fault pin only pulls low when active
   assign fan_drive_o = drive;
   assign fan_drive_oe_o = (state == TFPS_ST_START) || (state == TFPS_ST_RUN);
   assign overtemp_fault_n_o = 1'b0;
   assign overtemp_fault_n_oe_o = fault; // see R03
   assign state_o = state;

   property p_startup_high;
      @(posedge clk_i) disable iff (reset_i || shutdown_i)
      (state == TFPS_ST_START) |-> (drive && fan_drive_oe_o);
   endproperty
   a_startup_high: assert property (p_startup_high) else $error("drive low in startup"); // see R08

   property p_full_duty;
      @(posedge clk_i) disable iff (reset_i || shutdown_i)
      (next_state == TFPS_ST_RUN && cmp_i.full_duty) |=> drive;
   endproperty
   a_full_duty: assert property (p_full_duty) else $error("full duty not held"); // see R02

   property p_fault_set;
      @(posedge clk_i) disable iff (reset_i || shutdown_i)
      (state == TFPS_ST_RUN && next_state == TFPS_ST_RUN && cmp_i.overtemp) |=> overtemp_fault_n_oe_o;
   endproperty
   a_fault_set: assert property (p_fault_set) else $error("fault not raised"); // see R03

   property p_fault_clear;
      @(posedge clk_i) disable iff (reset_i || shutdown_i)
      !cmp_i.overtemp |=> !fault;
   endproperty
   a_fault_clear: assert property (p_fault_clear) else $error("fault not released"); // see R04

   property p_sleep_enter;
      @(posedge clk_i) disable iff (reset_i || shutdown_i)
      (state == TFPS_ST_RUN && sleep_req) |=> (state == TFPS_ST_SLEEP);
   endproperty
   a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered"); // see R05

   property p_one_low_runs;
      @(posedge clk_i) disable iff (reset_i || shutdown_i)
      (state == TFPS_ST_RUN && !sleep_req) |=> (state == TFPS_ST_RUN);
   endproperty
   a_one_low_runs: assert property (p_one_low_runs) else $error("left run wrongly"); // see R06

   sequence s_wake;
      (state == TFPS_ST_SLEEP) && wake_req;
   endsequence
   sequence s_startup_entry;
      (state == TFPS_ST_START) && drive;
   endsequence
   property p_wake;
      @(posedge clk_i) disable iff (reset_i || shutdown_i)
      s_wake |=> s_startup_entry ##[START_LEN:START_LEN] (state == TFPS_ST_RUN && $past(state) == TFPS_ST_START);
   endproperty
   a_wake: assert property (p_wake) else $error("wake startup wrong"); // see R07

   property p_sleep_quiet;
      @(posedge clk_i) disable iff (reset_i || shutdown_i)
      (state == TFPS_ST_SLEEP) |-> (!drive && !fault && !fan_drive_oe_o);
   endproperty
   a_sleep_quiet: assert property (p_sleep_quiet) else $error("activity in sleep"); // see R12

   property p_restart;
      @(posedge clk_i) disable iff (reset_i || shutdown_i)
      (state == TFPS_ST_SHUT && cmp_i.restart) |=> (state == TFPS_ST_START && !fault);
   endproperty
   a_restart: assert property (p_restart) else $error("restart not as power-up"); // see R11

   property p_shut_off;
      @(posedge clk_i) disable iff (reset_i)
      shutdown_i |-> (state == TFPS_ST_SHUT && !drive && !fault);
   endproperty
   a_shut_off: assert property (p_shut_off) else $error("shutdown not immediate"); // see R09
endmodule
`default_nettype wire

// *** tb/tfps_env_model.sv ***
// Model of the thermistor network comparators, the fan transistor and the fault pull-up
`timescale 1ns/1ps
`default_nettype none
module tfps_env_model
   import tfps_pkg::*;
#(
   parameter logic [7:0] SHUT_LV = 8'h10,
   parameter logic [7:0] RESTART_LV = 8'h20,
   parameter logic [7:0] SLEEP_LV = 8'h40,
   parameter logic [7:0] WAKE_LV = 8'h60,
   parameter logic [7:0] FULL_LV = 8'he0,
   parameter logic [7:0] OT_LV = 8'hf0
) (
   input wire logic [7:0] primary_i,
   input wire logic [7:0] secondary_i,
   input wire logic drive_i,
   input wire logic drive_oe_i,
   input wire logic fault_n_i,
   input wire logic fault_oe_i,
   output tfps_cmp_t cmp_o,
   output logic shutdown_o,
   output logic fan_on_o,
   output logic fault_line_n_o
);
   // Gap between the two levels keeps shutdown and restart from chattering
   assign shutdown_o = primary_i < SHUT_LV;
   always_comb begin
      cmp_o.restart = primary_i > RESTART_LV;
      cmp_o.primary_below_sleep = primary_i < SLEEP_LV;
      cmp_o.secondary_below_sleep = secondary_i < SLEEP_LV;
      cmp_o.primary_above_wake = primary_i > WAKE_LV;
      cmp_o.secondary_above_wake = secondary_i > WAKE_LV;
      cmp_o.overtemp = primary_i > OT_LV;
      cmp_o.full_duty = primary_i > FULL_LV;
   end
   // Base resistor pulls a floating drive pin low, so the fan stops
   assign fan_on_o = drive_oe_i & drive_i;
   assign fault_line_n_o = fault_oe_i ? fault_n_i : 1'b1;
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking testbench of the thermal fan sequencer core
`timescale 1ns/1ps
`default_nettype none
module testbench
   import tfps_pkg::*;
;
   localparam int SP = 8;
   logic clk_i, reset_i, shutdown_i, drive, drive_oe, fault_n, fault_oe, fan_on, fault_line_n;
   logic [7:0] pri, sec;
   tfps_cmp_t cmp;
   tfps_state_t state_o;
   int miscompares = 0;
   int tests_run = 0;

   tfps_core #(.STARTUP_PERIODS(SP)) i_tfps_core (.clk_i(clk_i), .reset_i(reset_i), .shutdown_i(shutdown_i),
      .cmp_i(cmp), .primary_temp_input_i(pri), .secondary_fan_input_i(sec), .fan_drive_o(drive),
      .fan_drive_oe_o(drive_oe), .overtemp_fault_n_o(fault_n), .overtemp_fault_n_oe_o(fault_oe), .state_o(state_o));
   tfps_env_model i_tfps_env_model (.primary_i(pri), .secondary_i(sec), .drive_i(drive), .drive_oe_i(drive_oe),
      .fault_n_i(fault_n), .fault_oe_i(fault_oe), .cmp_o(cmp), .shutdown_o(shutdown_i), .fan_on_o(fan_on),
      .fault_line_n_o(fault_line_n));

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
      tests_run++;
      if (exp !== got) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic wait_state(input tfps_state_t st);
      int n;
      n = 0;
      while (state_o !== st && n < 300) begin
         step(1);
         n++;
      end
      chk("state", 9'(st), 9'(state_o));
      if (n == 300) report_and_stop();
   endtask

   task automatic startup_run();
      int n;
      n = 0;
      wait_state(TFPS_ST_START);
      while (state_o === TFPS_ST_START && n < 300) begin
         chk("startup drive", 9'h001, {8'h00, fan_on});
         step(1);
         n++;
      end
      chk("startup length", 9'(SP), 9'(n));
      if (n == 300) report_and_stop();
      chk("after startup", 9'(TFPS_ST_RUN), 9'(state_o));
   endtask

   // Counts high cycles over one full modulation period of 256 time-base cycles
   task automatic duty(input logic [7:0] p, input logic [7:0] s, input logic [8:0] exp);
      int n;
      pri = p;
      sec = s;
      step(3);
      n = 0;
      repeat (256) begin
         n += int'(fan_on === 1'b1);
         step(1);
      end
      chk("duty", exp, 9'(n));
   endtask

   task automatic t_power_up();
      chk("reset state", 9'(TFPS_ST_SHUT), 9'(state_o));
      chk("reset oe", 9'h000, {7'h00, drive_oe, fault_oe});
      reset_i = 1'b0;
      startup_run();
      $display("test power_up done");
   endtask

   task automatic t_control();
      duty(8'h70, 8'h90, 9'h090);
      duty(8'h90, 8'h70, 9'h090);
      duty(8'he8, 8'h00, 9'h100);
      chk("fault idle", 9'h001, {8'h00, fault_line_n});
      $display("test control done");
   endtask

   task automatic t_fault();
      pri = 8'hf8;
      step(2);
      repeat (8) begin
         chk("fault on", 9'h000, {fan_on, fault_line_n} ^ 9'h002);
         step(1);
      end
      pri = 8'hc0;
      step(1);
      chk("fault off", 9'h001, {8'h00, fault_line_n});
      duty(8'hc0, 8'h00, 9'h0c0);
      $display("test fault done");
   endtask

   task automatic t_sleep();
      pri = 8'h30;
      sec = 8'h90;
      step(20);
      chk("one below sleep", 9'(TFPS_ST_RUN), 9'(state_o));
      sec = 8'h30;
      wait_state(TFPS_ST_SLEEP);
      chk("sleep outputs", 9'h001, {fan_on, fault_line_n});
      sec = 8'h50;
      step(10);
      chk("hysteresis", 9'(TFPS_ST_SLEEP), 9'(state_o));
      sec = 8'h70;
      startup_run();
      $display("test sleep done");
   endtask

   task automatic t_shutdown();
      pri = 8'hf8;
      step(3);
      pri = 8'h08;
      sec = 8'h90;
      #1;
      chk("async shut", 9'(TFPS_ST_SHUT), 9'(state_o));
      chk("shut release", 9'h001, {drive_oe, fault_oe, fault_line_n});
      step(5);
      chk("stay shut", 9'(TFPS_ST_SHUT), 9'(state_o));
      pri = 8'h80;
      startup_run();
      chk("fault cleared", 9'h001, {8'h00, fault_line_n});
      $display("test shutdown done");
   endtask

   initial begin
      pri = 8'h80;
      sec = 8'h00;
      reset_i = 1'b1;
      repeat (8) @(posedge clk_i);
      #1;
      t_power_up();
      t_control();
      t_fault();
      t_sleep();
      t_shutdown();
      report_and_stop();
   end
endmodule
`default_nettype wire
